// ---- src/smie_exec.sv ----
// Executes shift-right, move-file and indirect-load operations for an 8-bit core.
// Assumes a data memory that returns the addressed byte within the read-strobe cycle.
// Contract
// RULE1 - Right shift moves each bit down one place, old bit 0 goes to carry, C and Z update.
// RULE2 - Right shift puts a zero into the top bit of the result.
// RULE3 - Shift destination bit 0 writes the accumulator, 1 writes the file register back.
// RULE4 - Move-file copies file register 0..127 to accumulator or itself by destination bit.
// RULE5 - Move-file sets Z from the moved value.
// RULE6 - Indirect load addresses pointer+1, pointer-1 or pointer+offset for pre and relative forms.
// RULE7 - After indirect load the pointer is +1 for increments, -1 for decrements, same for relative.
// RULE8 - Indirect load picks one of two pointers by one bit and takes a signed offset -32..31.
// RULE9 - Pointers are 16 bits and wrap modulo the full range.
// RULE10 - Indirect windows hold no storage; accesses go to the pointed-to location.
// RULE11 - Post modes use the unmodified pointer as address and update afterwards.
// RULE12 - Indirect load puts the byte into the accumulator and sets Z from it.
module smie_exec (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         ce_i,
	input  wire logic [1:0]                   op_i,
	input  wire logic                         op_valid_i,
	input  wire logic                         dest_sel_i,
	input  wire logic [smie_pkg::FADDR_W-1:0] file_addr_i,
	input  wire logic                         ptr_sel_i,
	input  wire logic [1:0]                   pointer_update_sel_i,
	input  wire logic                         rel_form_i,
	input  wire logic [smie_pkg::OFS_W-1:0]   offset_i,
	output logic                              busy_o,
	output logic                              done_o,
	output logic                              mem_rd_o,
	output logic                              mem_wr_o,
	output logic [smie_pkg::PTR_W-1:0]        mem_addr_o,
	output logic [smie_pkg::DATA_W-1:0]       mem_wdata_o,
	input  wire logic [smie_pkg::DATA_W-1:0]  mem_rdata_i,
	output logic [smie_pkg::DATA_W-1:0]       acc_o,
	output logic                              carry_o,
	output logic                              zero_o,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [3:0]                   wb_adr_i,
	input  wire logic [31:0]                  wb_dat_i,
	input  wire logic [3:0]                   wb_sel_i,
	output logic [31:0]                       wb_dat_o,
	output logic                              wb_ack_o
);
	import smie_pkg::*;

	// ****************************************
	// State
	// ****************************************
	smie_state_e           state_ff;
	smie_state_e           nxt_state;
	logic [DATA_W-1:0]     acc_ff;
	logic                  c_ff;
	logic                  z_ff;
	logic [PTR_W-1:0]      ptr_ff [2];
	logic                  op_is_file_ff;
	logic                  op_is_lsr_ff;
	logic                  dest_ff;
	logic                  psel_ff;
	logic [PTR_W-1:0]      ptr_new_ff;
	logic                  busy_ff;
	logic                  done_ff;
	logic                  rd_ff;
	logic                  wr_ff;
	logic [PTR_W-1:0]      addr_ff;
	logic [DATA_W-1:0]     wdata_ff;
	logic [31:0]           wb_dat_ff;
	logic                  wb_ack_ff;

	// ****************************************
	// Decode
	// ****************************************
	wire               start      = ce_i && op_valid_i && (op_i != OP_NONE) &&
		(state_ff == SMIE_IDLE);
	wire [PTR_W-1:0]   ptr_cur    = ptr_ff[ptr_sel_i]; // RULE8
	wire [PTR_W-1:0]   ptr_inc    = ptr_cur + PTR_ONE; // RULE9
	wire [PTR_W-1:0]   ptr_dec    = ptr_cur - PTR_ONE; // RULE9
	wire [PTR_W-1:0]   ofs_ext    = {{(PTR_W-OFS_W){offset_i[OFS_W-1]}}, offset_i}; // RULE8
	wire [PTR_W-1:0]   ptr_rel    = ptr_cur + ofs_ext;
	wire               is_inc     = !pointer_update_sel_i[0];
	// Pre forms address the updated pointer, post forms the old one.
	wire [PTR_W-1:0]   ind_addr   = rel_form_i ? ptr_rel :
		(pointer_update_sel_i == PUS_PRE_INC) ? ptr_inc : // RULE6
		(pointer_update_sel_i == PUS_PRE_DEC) ? ptr_dec : ptr_cur; // RULE11
	wire [PTR_W-1:0]   ind_ptr_nx = rel_form_i ? ptr_cur : (is_inc ? ptr_inc : ptr_dec); // RULE7
	wire [PTR_W-1:0]   file_addr  = {{(PTR_W-FADDR_W){1'b0}}, file_addr_i}; // RULE4
	// The indirect window is only an address; the fetched byte comes from the pointed location.
	wire [PTR_W-1:0]   start_addr = (op_i == OP_IND_LOAD) ? ind_addr : file_addr; // RULE10
	wire [DATA_W-1:0]  lsr_res    = {1'b0, mem_rdata_i[DATA_W-1:1]}; // RULE1 RULE2
	wire [DATA_W-1:0]  result     = op_is_lsr_ff ? lsr_res : mem_rdata_i;
	wire               res_zero   = (result == ACC_RST);
	wire               to_file    = op_is_file_ff && dest_ff; // RULE3 RULE4
	wire               finish     = ce_i && (state_ff == SMIE_READ);
	wire               nxt_busy   = start || (state_ff == SMIE_READ);
	wire               nxt_wr     = finish && to_file; // RULE3 RULE4

	wire               wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_ff;
	wire               wb_wr      = wb_req && wb_we_i && wb_sel_i[0] && ce_i;
	wire               wr_acc     = wb_wr && (wb_adr_i == ADR_ACC) && !busy_ff;
	wire               wr_stat    = wb_wr && (wb_adr_i == ADR_STATUS) && !busy_ff;
	wire               wr_p0      = wb_wr && (wb_adr_i == ADR_PTR0) && !busy_ff;
	wire               wr_p1      = wb_wr && (wb_adr_i == ADR_PTR1) && !busy_ff;
	// Unmapped offsets read as zero, so software probing the map sees no stale data.
	wire [31:0]        wb_rd_mux  =
		(wb_adr_i == ADR_ACC)    ? {24'h000000, acc_ff} :
		(wb_adr_i == ADR_STATUS) ? {29'h00000000, busy_ff, z_ff, c_ff} :
		(wb_adr_i == ADR_PTR0)   ? {16'h0000, ptr_ff[0]} :
		(wb_adr_i == ADR_PTR1)   ? {16'h0000, ptr_ff[1]} : 32'h00000000;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			SMIE_IDLE: if (start) nxt_state = SMIE_READ;
			SMIE_READ: if (ce_i) nxt_state = SMIE_DONE;
			SMIE_DONE: if (ce_i) nxt_state = SMIE_IDLE;
			default:   nxt_state = SMIE_IDLE;
		endcase
	end

	// ****************************************
	// Sequencer
	// ****************************************
	// Busy covers the read cycle and the done cycle, so a request held high
	// through an operation is taken once and refused until the core is idle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= SMIE_IDLE;
		end else if (ce_i) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff <= 1'b0;
		end else if (ce_i) begin
			busy_ff <= nxt_busy;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_ff <= 1'b0;
		end else if (ce_i) begin
			done_ff <= finish;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ff <= 1'b0;
		end else if (ce_i) begin
			rd_ff <= start;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ff <= 1'b0;
		end else if (ce_i) begin
			wr_ff <= nxt_wr;
		end
	end

	// ****************************************
	// Operand capture
	// ****************************************
	// Operands are latched at the take, so the instruction inputs may move on
	// while the read is outstanding. The take term already carries the enable.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_is_file_ff <= 1'b0;
			op_is_lsr_ff  <= 1'b0;
		end else if (start) begin
			op_is_file_ff <= (op_i != OP_IND_LOAD);
			op_is_lsr_ff  <= (op_i == OP_LSR);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_ff <= 1'b0;
			psel_ff <= 1'b0;
		end else if (start) begin
			dest_ff <= dest_sel_i;
			psel_ff <= ptr_sel_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_new_ff <= PTR_RST;
			addr_ff    <= PTR_RST;
		end else if (start) begin
			ptr_new_ff <= ind_ptr_nx;
			addr_ff    <= start_addr;
		end
	end

	// The write data is captured at the finish, so it stands with the write strobe.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdata_ff <= ACC_RST;
		end else if (finish) begin
			wdata_ff <= result;
		end
	end

	// ****************************************
	// Architectural state
	// ****************************************
	// A hardware update wins over a software write in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_ff <= ACC_RST;
		end else if (ce_i) begin
			if (finish) begin
				if (!to_file) begin
					acc_ff <= result; // RULE3 RULE12
				end
			end else if (wr_acc) begin
				acc_ff <= wb_dat_i[DATA_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c_ff <= 1'b0;
		end else if (ce_i) begin
			if (finish) begin
				if (op_is_lsr_ff) begin
					c_ff <= mem_rdata_i[0]; // RULE1
				end
			end else if (wr_stat) begin
				c_ff <= wb_dat_i[STAT_C_BIT];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			z_ff <= 1'b0;
		end else if (ce_i) begin
			if (finish) begin
				z_ff <= res_zero; // RULE5 RULE12
			end else if (wr_stat) begin
				z_ff <= wb_dat_i[STAT_Z_BIT];
			end
		end
	end

	// Each pointer takes the value prepared at the take, so it moves with the loaded byte.
	for (genvar i = 0; i < 2; i++) begin : g_ptr
		wire upd = finish && !op_is_file_ff && (psel_ff == 1'(i));
		wire swr = (i == 0) ? wr_p0 : wr_p1;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				ptr_ff[i] <= PTR_RST;
			end else if (ce_i) begin
				if (upd) begin
					ptr_ff[i] <= ptr_new_ff; // RULE7 RULE11
				end else if (swr) begin
					ptr_ff[i] <= wb_dat_i[PTR_W-1:0];
				end
			end
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	// Writes during an operation are dropped so the core state stays coherent.
	// The acknowledge term in the request keeps a strobe that is still high
	// after the acknowledge from being answered twice.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_ff <= 1'b0;
		end else if (ce_i) begin
			wb_ack_ff <= wb_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_ff <= 32'h00000000;
		end else if (ce_i) begin
			wb_dat_ff <= wb_req ? wb_rd_mux : 32'h00000000;
		end
	end

	assign busy_o      = busy_ff;
	assign done_o      = done_ff;
	assign mem_rd_o    = rd_ff;
	assign mem_wr_o    = wr_ff;
	assign mem_addr_o  = addr_ff;
	assign mem_wdata_o = wdata_ff;
	assign acc_o       = acc_ff;
	assign carry_o     = c_ff;
	assign zero_o      = z_ff;
	assign wb_dat_o    = wb_dat_ff;
	assign wb_ack_o    = wb_ack_ff;

endmodule

// ---- src/smie_pkg.sv ----
// Constants for the shift, move and indirect-load execution block.
// Assumes a core with 8-bit data, 7-bit file addresses and 16-bit pointers.
package smie_pkg;

	// ****************************************
	// Operation codes
	// ****************************************
	localparam logic [1:0] OP_NONE      = 2'h0;
	localparam logic [1:0] OP_LSR       = 2'h1;
	localparam logic [1:0] OP_MOVE_FILE = 2'h2;
	localparam logic [1:0] OP_IND_LOAD  = 2'h3;

	// ****************************************
	// Pointer update selection
	// ****************************************
	localparam logic [1:0] PUS_PRE_INC  = 2'h0;
	localparam logic [1:0] PUS_PRE_DEC  = 2'h1;
	localparam logic [1:0] PUS_POST_INC = 2'h2;
	localparam logic [1:0] PUS_POST_DEC = 2'h3;

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int          DATA_W     = 8;
	localparam int          FADDR_W    = 7;
	localparam int          PTR_W      = 16;
	localparam int          OFS_W      = 6;
	localparam logic [15:0] PTR_RST    = 16'h0000;
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [15:0] PTR_ONE    = 16'h0001;

	// ****************************************
	// Wishbone register map, word aligned byte addresses
	// ****************************************
	localparam logic [3:0] ADR_ACC    = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_PTR0   = 4'h8;
	localparam logic [3:0] ADR_PTR1   = 4'hC;
	localparam int         STAT_C_BIT = 0;
	localparam int         STAT_Z_BIT = 1;

	typedef enum logic [2:0] {
		SMIE_IDLE = 3'b001,
		SMIE_READ = 3'b010,
		SMIE_DONE = 3'b100
	} smie_state_e;

endpackage

// ---- tb/smie_exec_asserts.sv ----
// Port checks for the shift, move and indirect-load block.
// Assumes one clock domain; bound to every instance of the block.
module smie_exec_asserts
	import smie_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic [1:0]  op_i,
	input wire logic        op_valid_i,
	input wire logic        dest_sel_i,
	input wire logic [6:0]  file_addr_i,
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic        mem_rd_o,
	input wire logic        mem_wr_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic [7:0]  mem_wdata_o,
	input wire logic [7:0]  mem_rdata_i,
	input wire logic [7:0]  acc_o,
	input wire logic        carry_o,
	input wire logic        zero_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire       take = ce_i && op_valid_i && op_i != OP_NONE && !busy_o;
	wire       lsr  = take && op_i == OP_LSR;
	wire       mov  = take && op_i == OP_MOVE_FILE;
	wire       ld   = take && op_i == OP_IND_LOAD;
	wire [7:0] res  = mem_wr_o ? mem_wdata_o : acc_o;
	take_read_a: assert property (take |=> mem_rd_o)
		else $error("no read after take");
	file_addr_a: assert property (lsr || mov |=> mem_addr_o == {9'h000, $past(file_addr_i)})
		else $error("file address wrong");
	done_pulse_a: assert property (take ##1 ce_i |=> done_o ##1 !done_o)
		else $error("done not one pulse");
	shift_value_a: assert property (lsr ##1 ce_i |=> res == $past(mem_rdata_i) >> 1)
		else $error("shift result wrong");
	dest_write_a: assert property (lsr || mov ##1 ce_i |=> mem_wr_o == $past(dest_sel_i, 2))
		else $error("destination wrong");
	move_zero_a: assert property (mov ##1 ce_i |=> res == $past(mem_rdata_i)
		&& zero_o == (res == 8'h00)) else $error("move or zero wrong");
	load_acc_a: assert property (ld ##1 ce_i |=> acc_o == $past(mem_rdata_i)
		&& !mem_wr_o && zero_o == (acc_o == 8'h00)) else $error("load wrong");
	shift_carry_a: assert property (lsr ##1 ce_i |=> carry_o == $past(mem_rdata_i[0]))
		else $error("carry wrong");
	cover property (lsr && dest_sel_i);
	cover property (ld);
	cover property (op_valid_i && busy_o);
endmodule
bind smie_exec smie_exec_asserts i_chk (.*);

// ---- tb/smie_mem_model.sv ----
// Behavioural data memory and file registers facing the execution block.
// Assumes reads are strobed for one cycle and writes land at the clock edge.
module smie_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	logic [7:0] last_ff = 8'h00;
	// Outside the strobe the bus shows the inverse of the last byte, so a late sample is caught.
	assign rdata_o = rd_i ? mem[addr_i] : ~last_ff;
	always @(posedge clk_i) begin
		if (rd_i)
			last_ff <= mem[addr_i];
		if (wr_i)
			mem[addr_i] <= wdata_i;
	end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the shift, move and indirect-load block.
// Assumes the memory model answers reads in the strobe cycle.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import smie_pkg::*;
	typedef struct packed {
		logic [1:0]  op;
		logic        d;
		logic [6:0]  fa;
		logic        ps;
		logic [1:0]  pus;
		logic        rel;
		logic [5:0]  ofs;
		logic [15:0] ea;
		logic [7:0]  mv;
		logic [7:0]  res;
		logic [1:0]  cz;
		logic [15:0] ptr;
	} smie_row_s;
	logic        clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, dest_sel_i = 1'b0;
	logic        ptr_sel_i = 1'b0, rel_form_i = 1'b0, wb_cyc_i = 1'b0, ce_i = 1'b1;
	logic        wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [1:0]  op_i = 2'h0, pointer_update_sel_i = 2'h0;
	logic [6:0]  file_addr_i = 7'h00;
	logic [5:0]  offset_i = 6'h00;
	logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [15:0] mem_addr_o, cnt;
	logic [7:0]  mem_wdata_o, mem_rdata_i, acc_o;
	logic        busy_o, done_o, mem_rd_o, mem_wr_o, carry_o, zero_o, wb_ack_o;
	int          err_count = 0, samples_checked = 0, n;
	smie_row_s   rows [10] = '{
		'{2'h1,1'h0,7'h05,1'h0,2'h0,1'h0,6'h00,16'h0005,8'h80,8'h40,2'h0,16'h0000},
		'{2'h1,1'h1,7'h06,1'h0,2'h0,1'h0,6'h00,16'h0006,8'h01,8'h00,2'h3,16'h0000},
		'{2'h2,1'h0,7'h7F,1'h0,2'h0,1'h0,6'h00,16'h007F,8'h00,8'h00,2'h3,16'h0000},
		'{2'h2,1'h1,7'h05,1'h0,2'h0,1'h0,6'h00,16'h0005,8'h80,8'h80,2'h2,16'h0000},
		'{2'h3,1'h0,7'h00,1'h0,2'h1,1'h0,6'h00,16'hFFFF,8'h3C,8'h3C,2'h2,16'hFFFF},
		'{2'h3,1'h0,7'h00,1'h1,2'h0,1'h0,6'h00,16'h0000,8'h00,8'h00,2'h3,16'h0000},
		'{2'h3,1'h0,7'h00,1'h0,2'h2,1'h0,6'h00,16'hFFFF,8'h7E,8'h7E,2'h2,16'h0000},
		'{2'h3,1'h0,7'h00,1'h1,2'h3,1'h0,6'h00,16'h0000,8'h01,8'h01,2'h2,16'hFFFF},
		'{2'h3,1'h0,7'h00,1'h0,2'h0,1'h1,6'h20,16'hFFE0,8'hC3,8'hC3,2'h2,16'h0000},
		'{2'h3,1'h0,7'h00,1'h1,2'h0,1'h1,6'h1F,16'h001E,8'h00,8'h00,2'h3,16'hFFFF}};
	smie_exec i_dut (.*);
	smie_mem_model i_mem (.clk_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
		.wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			err_count++;
			final_report();
		end
		@(posedge clk_i);
	endtask
	task automatic run(input smie_row_s r);
		i_mem.mem[r.ea] = r.mv;
		{op_i, dest_sel_i, file_addr_i} <= {r.op, r.d, r.fa};
		{ptr_sel_i, pointer_update_sel_i, rel_form_i} <= {r.ps, r.pus, r.rel};
		offset_i   <= r.ofs;
		op_valid_i <= 1'b1;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		n = 0;
		cnt = 16'h0000;
		do begin
			@(posedge clk_i);
			n++;
			cnt += 16'(mem_rd_o === 1'b1);
			if (mem_rd_o === 1'b1)
				chk(mem_addr_o, r.ea);
		end while (done_o !== 1'b1 && n < 10);
		if (done_o !== 1'b1) begin
			err_count++;
			final_report();
		end
		chk(cnt, 16'h0001);
		chk(16'(busy_o), 16'h0001);
		q[7:0] = (r.op != 2'h3 && r.d) ? mem_wdata_o : acc_o;
		chk(16'(q[7:0]), 16'(r.res));
		chk(16'(mem_wr_o), 16'(r.op != 2'h3 && r.d));
		chk(16'({carry_o, zero_o}), 16'(r.cz));
		wb(1'b0, r.ps ? ADR_PTR1 : ADR_PTR0, 32'h0);
		chk(q[15:0], r.ptr);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, ADR_PTR0, 32'h0);
		chk(q[15:0], PTR_RST);
		chk(16'({acc_o, carry_o, zero_o}), 16'h0000);
		wb(1'b0, 4'h2, 32'h0);
		chk(q[15:0], 16'h0000);
		wb(1'b1, ADR_ACC, 32'h0000005A);
		wb(1'b0, ADR_ACC, 32'h0);
		chk(q[15:0], 16'h005A);
		wb(1'b1, ADR_STATUS, 32'h00000003);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(q[15:0], 16'h0003);
		$display("reset and map test done");
		wb(1'b1, ADR_PTR1, 32'h0000FFFF);
		for (int i = 0; i < 10; i++) begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		// A request held high through the busy cycles must start one operation only.
		{op_i, dest_sel_i, file_addr_i} <= {OP_MOVE_FILE, 1'b0, 7'h05};
		op_valid_i <= 1'b1;
		cnt = 16'h0000;
		repeat (3) begin
			@(posedge clk_i);
			cnt += 16'(mem_rd_o);
		end
		op_valid_i <= 1'b0;
		@(posedge clk_i);
		cnt += 16'(mem_rd_o);
		chk(cnt, 16'h0001);
		chk(16'(acc_o), 16'h0080);
		$display("refused request test done");
		// With the clock enable low a held request must not start; raising it lets it through.
		ce_i <= 1'b0;
		{op_i, dest_sel_i, file_addr_i} <= {OP_LSR, 1'b0, 7'h05};
		op_valid_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(16'({busy_o, mem_rd_o}), 16'h0000);
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		op_valid_i <= 1'b0;
		@(posedge clk_i);
		chk(16'({done_o, acc_o}), 16'h0140);
		$display("clock enable test done");
		final_report();
	end
endmodule
